// [core/fgr_pkg.sv]
// Constants of the fuel gauge register bank
package fgr_pkg;
  localparam logic [7:0] VBAT_HI_ADDR = 8'ha0;
  localparam logic [7:0] VBAT_LO_ADDR = 8'ha1;
  localparam logic [7:0] CTRL_ADDR = 8'hb8;
  localparam logic [7:0] RPT_ADDR = 8'hb9;
  localparam logic [7:0] RES_HI_ADDR = 8'hba;
  localparam logic [7:0] RES_LO_ADDR = 8'hbb;
  localparam logic [7:0] OCV_HI_ADDR = 8'hbc;
  localparam logic [7:0] OCV_LO_ADDR = 8'hbd;
  localparam logic [7:0] CAP_HI_ADDR = 8'he0;
  localparam logic [7:0] CAP_LO_ADDR = 8'he1;
  localparam logic [7:0] CNT_HI_ADDR = 8'he2;
  localparam logic [7:0] CNT_LO_ADDR = 8'he3;
  localparam logic [7:0] OCVP_ADDR = 8'he4;
  localparam logic [7:0] CNTP_ADDR = 8'he5;
  localparam logic [7:0] WARN_ADDR = 8'he6;
  localparam logic [7:0] IVL_ADDR = 8'he8;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'hf0;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hf1;
  localparam logic [7:0] CTRL_RST = 8'he8;
  localparam logic [7:0] PCT_RST = 8'h64;
  localparam logic [7:0] WARN_RST = 8'ha0;
  localparam logic [12:0] RES_RST = 13'h005d;
  localparam logic [7:0] WARN_BASE = 8'h05;
  localparam int BIT_GAUGE = 7;
  localparam int BIT_METER = 6;
  localparam int BIT_CAP_EN = 5;
  localparam int BIT_CAP_ST = 4;
  localparam int BIT_CRV_EN = 3;
  localparam int BIT_CRV_ST = 2;
  localparam int BIT_RES_EN = 7;
  localparam int BIT_RES_OK = 6;
  localparam int BIT_RES_SEEN = 5;
  localparam logic [2:0] IVL_NOW = 3'h4;
  // Interrupt status bits
  localparam int EV_VBAT = 0;
  localparam int EV_RES = 1;
  localparam int EV_RPT = 2;
  localparam int EV_WARN = 3;
  localparam int EV_SHUT = 4;
  localparam int EV_N = 5;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_S;
endpackage

// [core/fgr_bank.sv]
// Fuel gauge register bank with percentage update pacing and interrupts
`timescale 1ns/1ps
`default_nettype none
module fgr_bank #(
  parameter int SEC_CYCLES = fgr_pkg::SEC_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_vbat_stb,
  input wire logic [11:0] i_battery_sense_input,
  input wire logic i_ocv_stb,
  input wire logic [11:0] i_ocv,
  input wire logic i_ocvp_stb,
  input wire logic [7:0] i_ocvp,
  input wire logic i_cntp_stb,
  input wire logic [7:0] i_cntp,
  input wire logic i_ind_stb,
  input wire logic [7:0] i_ind,
  input wire logic i_charge_up,
  input wire logic i_charge_down,
  input wire logic i_cap_cal_active,
  input wire logic i_curve_cal_active,
  input wire logic i_res_done,
  input wire logic i_res_ok,
  input wire logic [12:0] i_res_value,
  output logic o_gauge_en,
  output logic o_meter_en,
  output logic o_cap_cal_en,
  output logic o_curve_cal_en,
  output logic o_res_en,
  output logic [12:0] o_battery_internal_resistance,
  output logic [14:0] o_max_capacity,
  output logic [14:0] o_charge_count,
  output logic o_low_warn,
  output logic o_shutdown,
  output logic o_irq
);
  typedef struct packed {
    logic gauge_en;
    logic meter_en;
    logic cap_en;
    logic crv_en;
    logic [7:0] rpt;
    logic res_en;
    logic res_ok;
    logic res_seen;
    logic [12:0] res;
    logic [11:0] vbat;
    logic [11:0] ocv;
    logic cap_valid;
    logic [14:0] cap;
    logic cnt_valid;
    logic [14:0] cnt;
    logic [7:0] ocvp;
    logic [7:0] cntp;
    logic [7:0] warn;
    logic [2:0] ivl;
    logic [31:0] sec_div;
    logic [7:0] sec_cnt;
    logic warn_q;
    logic shut_q;
    logic [fgr_pkg::EV_N-1:0] stat;
    logic [fgr_pkg::EV_N-1:0] mask;
    logic [7:0] rdata;
  } fgr_state_t;

  fgr_state_t st;
  fgr_state_t next_st;
  logic cap_busy;
  logic crv_busy;
  logic sec_tick;
  logic pace_ok;
  logic warn_now;
  logic shut_now;
  logic [fgr_pkg::EV_N-1:0] ev;

  // Update interval in seconds per code; zero means no pacing
  function automatic logic [7:0] ivl_secs(input logic [2:0] code);
    case (code)
      3'h0: ivl_secs = 8'h1e;
      3'h1: ivl_secs = 8'h3c;
      3'h2: ivl_secs = 8'h78;
      3'h3: ivl_secs = 8'ha4;
      3'h5: ivl_secs = 8'h05;
      3'h6: ivl_secs = 8'h0a;
      3'h7: ivl_secs = 8'h14;
      default: ivl_secs = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input fgr_state_t s, input logic [7:0] a,
                                          input logic cb, input logic vb);
    case (a)
      fgr_pkg::VBAT_HI_ADDR: reg_read = s.vbat[11:4];
      fgr_pkg::VBAT_LO_ADDR: reg_read = {s.vbat[3:0], 4'h0};
      fgr_pkg::CTRL_ADDR: reg_read = {s.gauge_en, s.meter_en, s.cap_en, cb,
                                      s.crv_en, vb, 2'h0};
      fgr_pkg::RPT_ADDR: reg_read = s.rpt;
      fgr_pkg::RES_HI_ADDR: reg_read = {s.res_en, s.res_ok, s.res_seen, s.res[12:8]};
      fgr_pkg::RES_LO_ADDR: reg_read = s.res[7:0];
      fgr_pkg::OCV_HI_ADDR: reg_read = s.ocv[11:4];
      fgr_pkg::OCV_LO_ADDR: reg_read = {4'h0, s.ocv[3:0]};
      fgr_pkg::CAP_HI_ADDR: reg_read = {s.cap_valid, s.cap[14:8]};
      fgr_pkg::CAP_LO_ADDR: reg_read = s.cap[7:0];
      fgr_pkg::CNT_HI_ADDR: reg_read = {s.cnt_valid, s.cnt[14:8]};
      fgr_pkg::CNT_LO_ADDR: reg_read = s.cnt[7:0];
      fgr_pkg::OCVP_ADDR: reg_read = s.ocvp;
      fgr_pkg::CNTP_ADDR: reg_read = s.cntp;
      fgr_pkg::WARN_ADDR: reg_read = s.warn;
      fgr_pkg::IVL_ADDR: reg_read = {5'h00, s.ivl};
      fgr_pkg::IRQ_STAT_ADDR: reg_read = {3'h0, s.stat};
      fgr_pkg::IRQ_MASK_ADDR: reg_read = {3'h0, s.mask};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Status bits follow the engines only while their enables are on
  assign cap_busy = st.gauge_en & st.cap_en & i_cap_cal_active;
  assign crv_busy = st.gauge_en & st.crv_en & i_curve_cal_active;
  assign sec_tick = (st.sec_div == 32'(SEC_CYCLES - 1));
  assign pace_ok = (st.ivl == fgr_pkg::IVL_NOW) || (st.sec_cnt >= ivl_secs(st.ivl));
  // Thresholds compare against a valid reported percentage only
  assign warn_now = st.rpt[7] &&
                    ({1'b0, st.rpt[6:0]} < fgr_pkg::WARN_BASE + {4'h0, st.warn[7:4]});
  assign shut_now = st.rpt[7] && ({1'b0, st.rpt[6:0]} < {4'h0, st.warn[3:0]});

  always_comb begin
    next_st = st;
    ev = '0;
    next_st.rdata = 8'h00;
    if (i_rd) begin
      next_st.rdata = reg_read(st, i_addr, cap_busy, crv_busy);
    end
    // Seconds base runs freely; the count saturates so long intervals still expire
    next_st.sec_div = sec_tick ? 32'h0 : st.sec_div + 32'h1;
    if (sec_tick && st.sec_cnt != 8'hff) begin
      next_st.sec_cnt = st.sec_cnt + 8'h01;
    end
    if (i_vbat_stb) begin
      next_st.vbat = i_battery_sense_input;
      ev[fgr_pkg::EV_VBAT] = 1'b1;
    end
    if (st.gauge_en) begin
      if (i_ocv_stb) begin
        next_st.ocv = i_ocv;
      end
      if (i_ocvp_stb) begin
        next_st.ocvp = i_ocvp;
      end
      if (i_ind_stb && i_ind != st.rpt && pace_ok) begin
        next_st.rpt = i_ind;
        next_st.sec_cnt = 8'h00;
        ev[fgr_pkg::EV_RPT] = 1'b1;
      end
      if (st.meter_en) begin
        if (i_cntp_stb) begin
          next_st.cntp = i_cntp;
        end
        if (i_charge_up && !i_charge_down && st.cnt != 15'h7fff) begin
          next_st.cnt = st.cnt + 15'h0001;
        end else if (i_charge_down && !i_charge_up && st.cnt != 15'h0000) begin
          next_st.cnt = st.cnt - 15'h0001;
        end
      end
      if (st.res_en && i_res_done) begin
        next_st.res_seen = 1'b1;
        next_st.res_ok = i_res_ok;
        if (i_res_ok) begin
          next_st.res = i_res_value;
        end
        ev[fgr_pkg::EV_RES] = 1'b1;
      end
    end
    next_st.warn_q = warn_now;
    next_st.shut_q = shut_now;
    ev[fgr_pkg::EV_WARN] = warn_now & ~st.warn_q;
    ev[fgr_pkg::EV_SHUT] = shut_now & ~st.shut_q;
    if (i_wr) begin
      case (i_addr)
        fgr_pkg::CTRL_ADDR: begin
          next_st.gauge_en = i_wdata[fgr_pkg::BIT_GAUGE];
          next_st.meter_en = i_wdata[fgr_pkg::BIT_METER];
          next_st.cap_en = i_wdata[fgr_pkg::BIT_CAP_EN];
          next_st.crv_en = i_wdata[fgr_pkg::BIT_CRV_EN];
        end
        fgr_pkg::RES_HI_ADDR: begin
          next_st.res_en = i_wdata[fgr_pkg::BIT_RES_EN];
          next_st.res[12:8] = i_wdata[4:0];
        end
        fgr_pkg::RES_LO_ADDR: next_st.res[7:0] = i_wdata;
        fgr_pkg::CAP_HI_ADDR: {next_st.cap_valid, next_st.cap[14:8]} = i_wdata;
        fgr_pkg::CAP_LO_ADDR: next_st.cap[7:0] = i_wdata;
        fgr_pkg::CNT_HI_ADDR: {next_st.cnt_valid, next_st.cnt[14:8]} = i_wdata;
        fgr_pkg::CNT_LO_ADDR: next_st.cnt[7:0] = i_wdata;
        fgr_pkg::WARN_ADDR: next_st.warn = i_wdata;
        fgr_pkg::IVL_ADDR: next_st.ivl = i_wdata[2:0];
        fgr_pkg::IRQ_MASK_ADDR: next_st.mask = i_wdata[fgr_pkg::EV_N-1:0];
        fgr_pkg::IRQ_STAT_ADDR: next_st.stat = st.stat & ~i_wdata[fgr_pkg::EV_N-1:0];
        default: next_st.stat = st.stat;
      endcase
    end
    // A new event wins over a write-one clear in the same cycle
    next_st.stat = next_st.stat | ev;
    // System reset leaves the power-on fields alone
    if (i_reset) begin
      next_st.vbat = 12'h000;
      next_st.gauge_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_GAUGE];
      next_st.meter_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_METER];
      next_st.cap_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_CAP_EN];
      next_st.crv_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_CRV_EN];
      next_st.res_ok = 1'b0;
      next_st.res_seen = 1'b0;
      next_st.sec_div = 32'h0;
      next_st.sec_cnt = 8'h00;
      next_st.stat = '0;
      next_st.mask = '0;
      next_st.warn_q = 1'b0;
      next_st.shut_q = 1'b0;
      next_st.rdata = 8'h00;
    end
    if (i_por) begin
      next_st = '0;
      next_st.gauge_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_GAUGE];
      next_st.meter_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_METER];
      next_st.cap_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_CAP_EN];
      next_st.crv_en = fgr_pkg::CTRL_RST[fgr_pkg::BIT_CRV_EN];
      next_st.rpt = fgr_pkg::PCT_RST;
      next_st.res_en = 1'b1;
      next_st.res = fgr_pkg::RES_RST;
      next_st.ocvp = fgr_pkg::PCT_RST;
      next_st.cntp = fgr_pkg::PCT_RST;
      next_st.warn = fgr_pkg::WARN_RST;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st <= next_st;
  end

  assign o_rdata = st.rdata;
  assign o_gauge_en = st.gauge_en;
  assign o_meter_en = st.gauge_en & st.meter_en;
  assign o_cap_cal_en = st.gauge_en & st.cap_en;
  assign o_curve_cal_en = st.gauge_en & st.crv_en;
  assign o_res_en = st.gauge_en & st.res_en;
  assign o_battery_internal_resistance = st.res;
  assign o_max_capacity = st.cap;
  assign o_charge_count = st.cnt;
  assign o_low_warn = st.warn_q;
  assign o_shutdown = st.shut_q;
  assign o_irq = |(st.stat & st.mask);

  default clocking cb_main @(posedge i_sys_clk); endclocking
  default disable iff (i_reset || i_por);

  sequence s_rd_lo;
    i_rd && i_addr == fgr_pkg::VBAT_LO_ADDR;
  endsequence
  sequence s_wr_ctrl_off;
    i_wr && i_addr == fgr_pkg::CTRL_ADDR && !i_wdata[fgr_pkg::BIT_GAUGE];
  endsequence

  AST_GAUGE_OFF_FREEZES: assert property (
    s_wr_ctrl_off ##1 (!i_wr && !i_por && !i_reset) |->
      ##1 $stable(st.cnt) && $stable(st.rpt) && !o_meter_en)
    else $error("Disabled gauge still updated values");
  AST_METER_GATE: assert property (
    !st.meter_en && !i_por |=> $stable(st.cnt) || $past(i_wr))
    else $error("Counter moved with meter disabled");
  AST_CAP_STATUS: assert property (
    i_rd && i_addr == fgr_pkg::CTRL_ADDR |=>
      o_rdata[fgr_pkg::BIT_CAP_ST] == $past(cap_busy))
    else $error("Capacity calibration status wrong");
  AST_CURVE_STATUS: assert property (
    i_rd && i_addr == fgr_pkg::CTRL_ADDR |=>
      o_rdata[fgr_pkg::BIT_CRV_ST] == $past(crv_busy) && o_rdata[1:0] == 2'h0)
    else $error("Curve calibration status wrong");
  AST_RPT_READONLY: assert property (
    i_wr && i_addr == fgr_pkg::RPT_ADDR && !i_ind_stb && !i_por |=> $stable(st.rpt))
    else $error("Reported percentage was written");
  AST_RES_SEEN: assert property (
    st.gauge_en && st.res_en && i_res_done && !i_wr |=> st.res_seen ##1 st.res_seen)
    else $error("Detection flag not set");
  AST_VBAT_LOW_NIBBLE: assert property (
    s_rd_lo |=> o_rdata[3:0] == 4'h0 && o_rdata[7:4] == $past(st.vbat[3:0]))
    else $error("Low nibble register wrong");
  AST_PACE: assert property (
    $changed(st.rpt) && !$past(i_por) |-> $past(st.ivl) == fgr_pkg::IVL_NOW ||
      $past(st.sec_cnt) >= ivl_secs($past(st.ivl)))
    else $error("Reported percentage changed too early");
  AST_IRQ_LEVEL: assert property (
    ev != '0 && (ev & st.mask) != '0 |=> o_irq [*2] or (o_irq ##1 $past(i_wr)))
    else $error("Interrupt not raised");
  AST_CTRL_DEFAULT: assert property (
    disable iff (1'b0) i_reset || i_por |=>
      st.gauge_en && st.meter_en && st.cap_en && st.crv_en)
    else $error("Control enables not restored by reset");
  AST_SYS_RESET_KEEPS: assert property (
    disable iff (i_por) i_reset && !i_wr && !i_res_done && !i_charge_up && !i_charge_down |=>
      $stable(st.res) && $stable(st.res_en) && $stable(st.cap) && $stable(st.cnt))
    else $error("System reset changed a power-on field");
  AST_RES_FLAGS_CLEAR: assert property (
    disable iff (i_por) i_reset |=> !st.res_ok && !st.res_seen)
    else $error("Detection flags survived system reset");
  AST_READ_IDLE_ZERO: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data present without a read");
  AST_VBAT_HIGH_BYTE: assert property (
    i_rd && i_addr == fgr_pkg::VBAT_HI_ADDR |=> o_rdata == $past(st.vbat[11:4]))
    else $error("Voltage high byte wrong");
  AST_OCV_LOW_RESERVED: assert property (
    i_rd && i_addr == fgr_pkg::OCV_LO_ADDR |=> o_rdata[7:4] == 4'h0)
    else $error("Open-circuit low register reserved bits set");
  AST_IVL_RESERVED: assert property (
    i_rd && i_addr == fgr_pkg::IVL_ADDR |=> o_rdata[7:3] == 5'h00)
    else $error("Interval register reserved bits set");
  AST_RES_LOW_WRITE: assert property (
    i_wr && i_addr == fgr_pkg::RES_LO_ADDR |=> st.res[7:0] == $past(i_wdata))
    else $error("Resistance low byte not written");
  AST_CAP_WRITE: assert property (
    i_wr && i_addr == fgr_pkg::CAP_HI_ADDR |=> {st.cap_valid, st.cap[14:8]} == $past(i_wdata))
    else $error("Capacity high byte not written");
  AST_CNT_WRITE: assert property (
    i_wr && i_addr == fgr_pkg::CNT_LO_ADDR |=> st.cnt[7:0] == $past(i_wdata))
    else $error("Counter low byte not written");
  AST_WARN_WRITE: assert property (
    i_wr && i_addr == fgr_pkg::WARN_ADDR |=> st.warn == $past(i_wdata))
    else $error("Warning thresholds not written");
  AST_WARN_INVALID: assert property (
    !st.rpt[7] |=> !o_low_warn && !o_shutdown)
    else $error("Warning raised on an invalid percentage");
  AST_RPT_TAKEN: assert property (
    st.gauge_en && st.ivl == fgr_pkg::IVL_NOW && i_ind_stb && i_ind != st.rpt |=>
      st.rpt == $past(i_ind))
    else $error("Immediate percentage update missed");
  AST_OCV_HOLD_OFF: assert property (
    !st.gauge_en && !i_por |=> $stable(st.ocv) && $stable(st.ocvp) && $stable(st.cntp))
    else $error("Estimator values moved with gauge disabled");
endmodule
`default_nettype wire

// [tb/fgr_bank_tb_top.sv]
// Self-checking bench for the fuel gauge register bank
`timescale 1ns/1ps
`default_nettype none
module fgr_bank_tb_top;
  logic i_sys_clk = 1'h0, i_reset = 1'h1, i_por = 1'h1, i_wr, i_rd, i_res_ok;
  logic i_cap_cal_active, i_curve_cal_active;
  logic [7:0] i_addr, i_wdata, i_ocvp, i_cntp, i_ind, stb, o_rdata;
  logic [11:0] i_battery_sense_input, i_ocv;
  logic [12:0] i_res_value, o_battery_internal_resistance;
  logic o_gauge_en, o_meter_en, o_cap_cal_en, o_curve_cal_en, o_res_en;
  logic o_low_warn, o_shutdown, o_irq;
  logic [14:0] o_max_capacity, o_charge_count;
  wire i_vbat_stb = stb[0], i_ocv_stb = stb[1], i_ocvp_stb = stb[2], i_cntp_stb = stb[3];
  wire i_ind_stb = stb[4], i_charge_up = stb[5], i_charge_down = stb[6], i_res_done = stb[7];
  int fail_count = 0, n_checks = 0, cyc = 0;
  logic [7:0] q[$];
  logic pend = 1'h0;
  logic [15:0] lf = 16'h2b55, r;
  // Address and value after power-on reset; e7 is unmapped
  logic [15:0] rt [18] = '{16'ha000, 16'ha100, 16'hb8e8, 16'hb964, 16'hba80, 16'hbb5d,
    16'hbc00, 16'hbd00, 16'he000, 16'he100, 16'he200, 16'he300, 16'he464, 16'he564,
    16'he6a0, 16'he800, 16'he700, 16'hf000};

  // Short sim second so pacing fits in a few hundred cycles
  fgr_bank #(.SEC_CYCLES(10)) u_fgr_bank (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_por(i_por), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_vbat_stb(i_vbat_stb), .i_battery_sense_input(i_battery_sense_input),
    .i_ocv_stb(i_ocv_stb), .i_ocv(i_ocv), .i_ocvp_stb(i_ocvp_stb), .i_ocvp(i_ocvp),
    .i_cntp_stb(i_cntp_stb), .i_cntp(i_cntp), .i_ind_stb(i_ind_stb), .i_ind(i_ind),
    .i_charge_up(i_charge_up), .i_charge_down(i_charge_down),
    .i_cap_cal_active(i_cap_cal_active), .i_curve_cal_active(i_curve_cal_active),
    .i_res_done(i_res_done), .i_res_ok(i_res_ok), .i_res_value(i_res_value),
    .o_gauge_en(o_gauge_en), .o_meter_en(o_meter_en), .o_cap_cal_en(o_cap_cal_en),
    .o_curve_cal_en(o_curve_cal_en), .o_res_en(o_res_en),
    .o_battery_internal_resistance(o_battery_internal_resistance),
    .o_max_capacity(o_max_capacity), .o_charge_count(o_charge_count),
    .o_low_warn(o_low_warn), .o_shutdown(o_shutdown), .o_irq(o_irq));

  initial forever #5 i_sys_clk = ~i_sys_clk;

  function logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'h0;
  endtask

  // Expected value is queued; the watcher compares it one cycle later
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    q.push_back(e);
    @(posedge i_sys_clk);
    i_rd <= 1'h0;
  endtask

  task pulse(input int b);
    @(posedge i_sys_clk);
    stb[b] <= 1'h1;
    @(posedge i_sys_clk);
    stb[b] <= 1'h0;
  endtask

  task rst(input logic p);
    @(posedge i_sys_clk);
    {i_por, i_reset} <= {p, ~p};
    @(posedge i_sys_clk);
    {i_por, i_reset} <= 2'h0;
  endtask

  task tbl();
    for (int k = 0; k < 18; k++) rd(rt[k][15:8], rt[k][7:0]);
  endtask

  // Negedge sampling keeps the compare clear of the launching edge
  always @(negedge i_sys_clk) begin
    if (pend)
      check(o_rdata, q.pop_front());
    pend = i_rd;
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    {stb, i_wr, i_rd, i_cap_cal_active, i_curve_cal_active, i_res_ok} = '0;
    {i_addr, i_wdata, i_ocvp, i_cntp, i_ind, i_battery_sense_input, i_ocv, i_res_value} = '0;
    tick(3);
    {i_por, i_reset} <= 2'h0;
    tbl();
    check({o_gauge_en, o_meter_en, o_cap_cal_en, o_curve_cal_en, o_res_en}, 5'h1f);
    check(o_battery_internal_resistance, 13'h005d);
    $display("test reset done");
    i_cap_cal_active <= 1'h1;
    i_curve_cal_active <= 1'h1;
    rd(8'hb8, 8'hfc);
    wr(8'hb8, 8'h17);
    rd(8'hb8, 8'h00);
    i_ocv <= 12'habc;
    pulse(1);
    rd(8'hbc, 8'h00);
    wr(8'hb8, 8'h80);
    pulse(5);
    check({o_gauge_en, o_meter_en, o_cap_cal_en, o_curve_cal_en, o_res_en}, 5'h11);
    check(o_charge_count, 15'h0000);
    wr(8'hb8, 8'h68);
    rd(8'hb8, 8'h68);
    check({o_gauge_en, o_meter_en, o_cap_cal_en, o_curve_cal_en}, 4'h0);
    wr(8'hb8, 8'he8);
    rd(8'hb8, 8'hfc);
    {i_cap_cal_active, i_curve_cal_active} <= 2'h0;
    rd(8'hb8, 8'he8);
    $display("test control done");
    r = rnd();
    i_battery_sense_input <= r[11:0];
    i_ocv <= r[15:4];
    i_ocvp <= 8'hb7;
    i_cntp <= 8'hc2;
    for (int k = 0; k < 4; k++) pulse(k);
    wr(8'he4, 8'h00);
    wr(8'hb9, 8'h00);
    rd(8'ha0, r[11:4]);
    rd(8'ha1, {r[3:0], 4'h0});
    rd(8'hbc, r[15:8]);
    rd(8'hbd, {4'h0, r[7:4]});
    rd(8'he4, 8'hb7);
    rd(8'he5, 8'hc2);
    rd(8'hb9, 8'h64);
    $display("test samples done");
    r = rnd();
    wr(8'hba, r[7:0]);
    wr(8'hbb, r[15:8]);
    rd(8'hba, {r[7], 2'h0, r[4:0]});
    rd(8'hbb, r[15:8]);
    check(o_battery_internal_resistance, {r[4:0], r[15:8]});
    check(o_res_en, r[7]);
    wr(8'hba, 8'h80);
    i_res_value <= 13'h1abc;
    i_res_ok <= 1'h1;
    pulse(7);
    rd(8'hba, 8'hfa);
    rd(8'hbb, 8'hbc);
    rst(1'h0);
    rd(8'hba, 8'h9a);
    $display("test resistance done");
    r = rnd();
    wr(8'he0, r[15:8]);
    wr(8'he1, r[7:0]);
    rd(8'he0, r[15:8]);
    rd(8'he1, r[7:0]);
    check(o_max_capacity, r[14:0]);
    wr(8'he2, 8'h80);
    wr(8'he3, 8'h10);
    pulse(5);
    tick(1);
    check(o_charge_count, 15'h0011);
    pulse(6);
    rd(8'he2, 8'h80);
    rst(1'h0);
    rd(8'he3, 8'h10);
    $display("test capacity done");
    wr(8'he8, 8'hfc);
    rd(8'he8, 8'h04);
    i_ind <= 8'h8c;
    pulse(4);
    rd(8'hb9, 8'h8c);
    for (int k = 0; k < 16; k++) begin
      wr(8'he6, {k[3:0], k[3:0]});
      rd(8'he6, {k[3:0], k[3:0]});
      tick(2);
      check({o_low_warn, o_shutdown}, {k > 7, k > 12});
    end
    wr(8'he8, 8'h05);
    tick(60);
    i_ind <= 8'h8d;
    pulse(4);
    i_ind <= 8'h8e;
    pulse(4);
    rd(8'hb9, 8'h8d);
    tick(60);
    pulse(4);
    rd(8'hb9, 8'h8e);
    $display("test pacing done");
    wr(8'hf1, 8'h00);
    wr(8'hf0, 8'h1f);
    rd(8'hf0, 8'h00);
    pulse(0);
    rd(8'hf0, 8'h01);
    check(o_irq, 1'h0);
    wr(8'hf1, 8'h01);
    tick(2);
    check(o_irq, 1'h1);
    wr(8'hf0, 8'h01);
    tick(2);
    check(o_irq, 1'h0);
    pulse(0);
    tick(1);
    check(o_irq, 1'h1);
    wr(8'hf0, 8'h01);
    tick(2);
    check(o_irq, 1'h0);
    $display("test interrupt done");
    rst(1'h1);
    tbl();
    $display("test power-on done");
    tick(3);
    end_of_test();
  end
endmodule
`default_nettype wire
